// ---- dsls_pkg.sv ----
// package: constants, encodings and lookups for the display serial lane receiver
//----------------------------------------------------------------------
// Overview of operation
// - code 0Eh is 565 colour, 16 UI
// - code 1Eh is packed 666, 18 UI
// - code 2Eh is loose 666, 24 UI
// - code 3Eh is 888, loose-666 rate limits
// - each turnaround state period lasts 50-75 ns
// - module drives LP-00 five periods when taking lane
// - termination on within 35 ns+4UI
//----------------------------------------------------------------------
package dsls_pkg;

   //----------------------------------------------------------------------
   // timing
   //----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int LP_MIN_NS = 50;
   localparam int LP_MAX_NS = 75;
   localparam int EOT_MIN_NS = 40;
   localparam int LP_MIN_CYC = (LP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LP_MAX_CYC = LP_MAX_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] LP_DRIVE_CYC = CNT_W'((LP_MIN_CYC + LP_MAX_CYC) / 2);
   localparam logic [CNT_W-1:0] EOT_CYC = CNT_W'((EOT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int HOST_TA_PERIODS = 4;
   localparam int DEV_TA_PERIODS = 5;
   // host hold time plus one period of settling before the module drives
   localparam logic [CNT_W-1:0] TA_WAIT_CYC = CNT_W'((HOST_TA_PERIODS + 1) * LP_MIN_CYC);
   localparam logic [3:0] DEV_STEPS = 4'hB;

   //----------------------------------------------------------------------
   // lane levels {dp, dn} and pixel codes
   //----------------------------------------------------------------------
   localparam logic [1:0] LP_11 = 2'h3;
   localparam logic [1:0] LP_10 = 2'h2;
   localparam logic [1:0] LP_01 = 2'h1;
   localparam logic [1:0] LP_00 = 2'h0;
   localparam logic [7:0] DT_RGB565 = 8'h0E;
   localparam logic [7:0] DT_RGB666 = 8'h1E;
   localparam logic [7:0] DT_RGB666L = 8'h2E;
   localparam logic [7:0] DT_RGB888 = 8'h3E;
   localparam logic [4:0] BPP_16 = 5'h10;
   localparam logic [4:0] BPP_18 = 5'h12;
   localparam logic [4:0] BPP_24 = 5'h18;
   localparam logic [9:0] RATE_565_2L = 10'h236;
   localparam logic [9:0] RATE_565_3L = 10'h1D2;
   localparam logic [9:0] RATE_565_4L = 10'h16E;
   localparam logic [9:0] RATE_666_2L = 10'h27D;
   localparam logic [9:0] RATE_666_3L = 10'h20D;
   localparam logic [9:0] RATE_666_4L = 10'h19C;
   localparam logic [9:0] RATE_24B_2L = 10'h352;
   localparam logic [9:0] RATE_24B_3L = 10'h2BC;
   localparam logic [9:0] RATE_24B_4L = 10'h226;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_HSREQ = 9'h002,
      ST_HS = 9'h004,
      ST_EOT = 9'h008,
      ST_TA1 = 9'h010,
      ST_TA2 = 9'h020,
      ST_TA3 = 9'h040,
      ST_TA4 = 9'h080,
      ST_DRV = 9'h100
   } dsls_state_t;

   //----------------------------------------------------------------------
   // lookups
   //----------------------------------------------------------------------
   // returns {accepted, format index}
   function automatic logic [2:0] dsls_decode_dt(input logic [7:0] code);
      case (code)
         DT_RGB565: return 3'h4;
         DT_RGB666: return 3'h5;
         DT_RGB666L: return 3'h6;
         DT_RGB888: return 3'h7;
         default: return 3'h0;
      endcase
   endfunction

   function automatic logic [4:0] dsls_bpp(input logic [1:0] idx);
      case (idx)
         2'h0: return BPP_16;
         2'h1: return BPP_18;
         default: return BPP_24;
      endcase
   endfunction

   // zero for an unsupported lane count, so any nonzero rate is flagged
   function automatic logic [9:0] dsls_rate_limit(input logic [1:0] idx, input logic [2:0] lanes);
      logic [9:0] r;
      r = 10'h000;
      case (idx)
         2'h0: r = (lanes == 3'h2) ? RATE_565_2L : (lanes == 3'h3) ? RATE_565_3L :
                   (lanes == 3'h4) ? RATE_565_4L : 10'h000;
         2'h1: r = (lanes == 3'h2) ? RATE_666_2L : (lanes == 3'h3) ? RATE_666_3L :
                   (lanes == 3'h4) ? RATE_666_4L : 10'h000;
         default: r = (lanes == 3'h2) ? RATE_24B_2L : (lanes == 3'h3) ? RATE_24B_3L :
                   (lanes == 3'h4) ? RATE_24B_4L : 10'h000;
      endcase
      return r;
   endfunction

   function automatic logic [1:0] dsls_gray(input logic [1:0] b);
      return b ^ {1'b0, b[1]};
   endfunction

   // level driven at each step of the module's turn on lane 0
   function automatic logic [1:0] dsls_ta_level(input logic [3:0] step);
      if (step < 4'(DEV_TA_PERIODS)) begin
         return LP_00;
      end
      case (step)
         4'h5: return LP_10;
         4'h6: return LP_11;
         4'h7: return LP_10;
         4'h8: return LP_00;
         4'h9: return LP_10;
         default: return LP_00;
      endcase
   endfunction

endpackage

// ---- dsls_rx.sv ----
// module: lane 0 sequencing, termination control and pixel packet receive path
module dsls_rx #(
   parameter int DATA_W = 8
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic LINK_CLK,
   input wire logic LP_DP,
   input wire logic LP_DN,
   output logic LP_DP_O,
   output logic LP_DN_O,
   output logic LP_OE,
   output logic TERM_EN,
   input wire logic [2:0] LANE_COUNT,
   input wire logic [9:0] LANE_MBPS,
   output logic RATE_FAULT,
   input wire logic HS_VALID,
   input wire logic HS_SOP,
   input wire logic [DATA_W-1:0] HS_BYTE,
   output logic LINK_READY,
   output logic PIX_VALID,
   input wire logic PIX_READY,
   output logic [DATA_W-1:0] PIX_DATA,
   output logic PIX_FIRST,
   output logic [1:0] PIX_FMT,
   output logic [4:0] PIX_BPP
);

   localparam int ENT_W = DATA_W + 3;

   //----------------------------------------------------------------------
   // reset synchronisers, one per domain
   //----------------------------------------------------------------------
   logic [1:0] srst;
   logic [1:0] lrst;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         srst <= 2'h0;
      end else begin
         srst <= {srst[0], 1'b1};
      end
   end

   always_ff @(posedge LINK_CLK or negedge RESETN) begin
      if (!RESETN) begin
         lrst <= 2'h0;
      end else begin
         lrst <= {lrst[0], 1'b1};
      end
   end

   //----------------------------------------------------------------------
   // state types
   //----------------------------------------------------------------------
   typedef struct packed {
      logic in_pkt;
      logic [1:0] fmt;
      logic first;
      logic [1:0] wbin;
      logic [1:0] wgray;
      logic [1:0] rg1;
      logic [1:0] rg2;
      logic rdy;
      logic [1:0][ENT_W-1:0] mem;
   } dsls_link_t;

   typedef struct packed {
      logic [1:0] lp1;
      logic [1:0] lp2;
      logic [2:0] lanes1;
      logic [2:0] lanes2;
      logic [9:0] mbps1;
      logic [9:0] mbps2;
      logic [1:0] wg1;
      logic [1:0] wg2;
      logic [1:0] rbin;
      logic [1:0] rgray;
      logic empty;
      logic ovalid;
      logic [DATA_W-1:0] odata;
      logic ofirst;
      logic [1:0] ofmt;
      logic [4:0] bpp;
      logic rate_fault;
      dsls_pkg::dsls_state_t state;
      logic [dsls_pkg::CNT_W-1:0] cnt;
      logic [3:0] step;
      logic [1:0] lvl;
      logic oe;
      logic term;
   } dsls_sys_t;

   // lane levels start at stop state so a reset never reads as a request
   localparam dsls_sys_t SYS_RST = '{
      state: dsls_pkg::ST_IDLE,
      empty: 1'b1,
      lp1: dsls_pkg::LP_11,
      lp2: dsls_pkg::LP_11,
      default: '0
   };
   localparam dsls_link_t LINK_RST = '{rdy: 1'b1, default: '0};

   dsls_link_t l;
   dsls_link_t next_l;
   dsls_sys_t s;
   dsls_sys_t next_s;

   //----------------------------------------------------------------------
   // link domain: header decode and buffer write
   //----------------------------------------------------------------------
   // the link clock may stop right after a frame, so a packet is framed
   // by the start flag of its header byte rather than by a falling valid
   always_comb begin
      logic [2:0] dec;
      logic wr;
      dec = dsls_pkg::dsls_decode_dt(HS_BYTE[7:0]);
      wr = 1'b0;
      next_l = l;
      next_l.rg1 = s.rgray;
      next_l.rg2 = l.rg1;
      if (HS_VALID) begin
         if (HS_SOP) begin
            next_l.in_pkt = dec[2];
            next_l.fmt = dec[1:0];
            next_l.first = 1'b1;
         end else if (l.in_pkt && l.rdy) begin
            wr = 1'b1;
            next_l.mem[l.wbin[0]] = {l.first, l.fmt, HS_BYTE};
            next_l.first = 1'b0;
         end
      end
      next_l.wbin = l.wbin + {1'b0, wr};
      next_l.wgray = dsls_pkg::dsls_gray(next_l.wbin);
      // the stale read pointer can only hold ready low longer, never raise it early
      next_l.rdy = (next_l.wgray != ~l.rg2);
   end

   always_ff @(posedge LINK_CLK or negedge RESETN) begin
      if (!RESETN) begin
         l <= LINK_RST;
      end else if (!lrst[1]) begin
         l <= LINK_RST;
      end else begin
         l <= next_l;
      end
   end

   //----------------------------------------------------------------------
   // system domain: buffer read, lane 0 sequencing
   //----------------------------------------------------------------------
   always_comb begin
      logic pop;
      logic [ENT_W-1:0] ent;
      logic [1:0] lp;
      pop = !s.empty && (!s.ovalid || PIX_READY);
      ent = l.mem[s.rbin[0]];
      lp = s.lp2;
      next_s = s;
      next_s.lp1 = {LP_DP, LP_DN};
      next_s.lp2 = s.lp1;
      next_s.lanes1 = LANE_COUNT;
      next_s.lanes2 = s.lanes1;
      next_s.mbps1 = LANE_MBPS;
      next_s.mbps2 = s.mbps1;
      next_s.wg1 = l.wgray;
      next_s.wg2 = s.wg1;

      // output stage: a stalled receiver leaves the word in place
      if (s.ovalid && PIX_READY) begin
         next_s.ovalid = 1'b0;
      end
      if (pop) begin
         next_s.ovalid = 1'b1;
         next_s.odata = ent[DATA_W-1:0];
         next_s.ofmt = ent[DATA_W+1:DATA_W];
         next_s.ofirst = ent[DATA_W+2];
         if (ent[DATA_W+2]) begin
            next_s.bpp = dsls_pkg::dsls_bpp(ent[DATA_W+1:DATA_W]);
            next_s.rate_fault = s.mbps2 >
               dsls_pkg::dsls_rate_limit(ent[DATA_W+1:DATA_W], s.lanes2);
         end
      end
      next_s.rbin = s.rbin + {1'b0, pop};
      next_s.rgray = dsls_pkg::dsls_gray(next_s.rbin);
      next_s.empty = (next_s.rgray == s.wg2);

      // lane 0 sequencing
      case (s.state)
         dsls_pkg::ST_IDLE: begin
            if (lp == dsls_pkg::LP_01) begin
               next_s.state = dsls_pkg::ST_HSREQ;
               next_s.term = 1'b1;
            end else if (lp == dsls_pkg::LP_10) begin
               next_s.state = dsls_pkg::ST_TA1;
            end
         end
         dsls_pkg::ST_HSREQ: begin
            if (lp == dsls_pkg::LP_00) begin
               next_s.state = dsls_pkg::ST_HS;
            end else if (lp != dsls_pkg::LP_01) begin
               next_s.state = dsls_pkg::ST_IDLE;
               next_s.term = 1'b0;
            end
         end
         dsls_pkg::ST_HS: begin
            if (lp == dsls_pkg::LP_11) begin
               next_s.state = dsls_pkg::ST_EOT;
               next_s.term = 1'b0;
               next_s.cnt = dsls_pkg::EOT_CYC;
            end
         end
         dsls_pkg::ST_EOT: begin
            // lane glitches of the trailing edge are not taken as a new request
            if (s.cnt <= 8'h01) begin
               next_s.state = dsls_pkg::ST_IDLE;
            end else begin
               next_s.cnt = s.cnt - 8'h01;
            end
         end
         dsls_pkg::ST_TA1: begin
            if (lp == dsls_pkg::LP_00) begin
               next_s.state = dsls_pkg::ST_TA2;
            end else if (lp != dsls_pkg::LP_10) begin
               next_s.state = dsls_pkg::ST_IDLE;
            end
         end
         dsls_pkg::ST_TA2: begin
            if (lp == dsls_pkg::LP_10) begin
               next_s.state = dsls_pkg::ST_TA3;
            end else if (lp != dsls_pkg::LP_00) begin
               next_s.state = dsls_pkg::ST_IDLE;
            end
         end
         dsls_pkg::ST_TA3: begin
            if (lp == dsls_pkg::LP_00) begin
               next_s.state = dsls_pkg::ST_TA4;
               next_s.cnt = dsls_pkg::TA_WAIT_CYC;
            end else if (lp != dsls_pkg::LP_10) begin
               next_s.state = dsls_pkg::ST_IDLE;
            end
         end
         dsls_pkg::ST_TA4: begin
            // the wire floats once the host lets go, so the level is not read here
            if (s.cnt <= 8'h01) begin
               next_s.state = dsls_pkg::ST_DRV;
               next_s.step = 4'h0;
               next_s.cnt = dsls_pkg::LP_DRIVE_CYC;
               next_s.oe = 1'b1;
               next_s.lvl = dsls_pkg::dsls_ta_level(4'h0);
            end else begin
               next_s.cnt = s.cnt - 8'h01;
            end
         end
         dsls_pkg::ST_DRV: begin
            if (s.cnt <= 8'h01) begin
               if (s.step == dsls_pkg::DEV_STEPS - 4'h1) begin
                  next_s.state = dsls_pkg::ST_IDLE;
                  next_s.oe = 1'b0;
                  next_s.lvl = dsls_pkg::LP_00;
               end else begin
                  next_s.step = s.step + 4'h1;
                  next_s.cnt = dsls_pkg::LP_DRIVE_CYC;
                  next_s.lvl = dsls_pkg::dsls_ta_level(s.step + 4'h1);
               end
            end else begin
               next_s.cnt = s.cnt - 8'h01;
            end
         end
         default: begin
            next_s.state = dsls_pkg::ST_IDLE;
            next_s.oe = 1'b0;
            next_s.term = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         s <= SYS_RST;
      end else if (!srst[1]) begin
         s <= SYS_RST;
      end else begin
         s <= next_s;
      end
   end

   //----------------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------------
   assign LP_DP_O = s.lvl[1];
   assign LP_DN_O = s.lvl[0];
   assign LP_OE = s.oe;
   assign TERM_EN = s.term;
   assign RATE_FAULT = s.rate_fault;
   assign LINK_READY = l.rdy;
   assign PIX_VALID = s.ovalid;
   assign PIX_DATA = s.odata;
   assign PIX_FIRST = s.ofirst;
   assign PIX_FMT = s.ofmt;
   assign PIX_BPP = s.bpp;

endmodule

// ---- dsls_rx_properties.sv ----
// checker: lane timing and pixel stream properties at the receiver ports
module dsls_rx_properties #(
   parameter int DATA_W = 8
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic LP_DP,
   input wire logic LP_DN,
   input wire logic LP_DP_O,
   input wire logic LP_DN_O,
   input wire logic LP_OE,
   input wire logic TERM_EN,
   input wire logic PIX_VALID,
   input wire logic PIX_READY,
   input wire logic [DATA_W-1:0] PIX_DATA,
   input wire logic PIX_FIRST,
   input wire logic [1:0] PIX_FMT,
   input wire logic [4:0] PIX_BPP
);
   timeunit 1ns;
   timeprecision 1ps;
   //--------------------------------------------------------------
   // helpers
   //--------------------------------------------------------------
   logic [1:0] lvl;
   logic [1:0] olvl;
   logic [1:0] prv;
   logic [7:0] run;
   assign lvl = {LP_DP, LP_DN};
   assign olvl = {LP_DP_O, LP_DN_O};
   // the five opening zero periods look like one, so count only after a change
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         prv <= 2'h0;
         run <= 8'h00;
      end else begin
         prv <= olvl;
         run <= !LP_OE ? 8'h00 : (olvl != prv) ? 8'h01 : (run != 8'h00) ? run + 8'h01 : 8'h00;
      end
   end
   //--------------------------------------------------------------
   // properties
   //--------------------------------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   period_min_a: assert property (LP_OE && $past(LP_OE) && olvl != $past(olvl)
      |=> $stable(olvl)[*6]) else $error("drive period too short");
   period_max_a: assert property (run <= 8'h09)
      else $error("drive period too long");
   takeover_zero_a: assert property ($rose(LP_OE)
      |-> (LP_OE && olvl == 2'h0)[*8] ##32 (LP_OE && olvl == 2'h0)) else $error("zero drive short");
   takeover_end_a: assert property ($rose(LP_OE) |-> ##[32:47] (olvl != 2'h0))
      else $error("zero drive long");
   term_on_a: assert property ($past(lvl) == 2'h3 && lvl == 2'h1 && !LP_OE
      |-> ##[1:4] TERM_EN) else $error("termination late");
   term_off_a: assert property (TERM_EN && lvl == 2'h3 |-> ##[1:4] !TERM_EN)
      else $error("termination kept after burst");
   drive_no_term_a: assert property (LP_OE |-> !TERM_EN)
      else $error("termination while driving");
   pix_hold_a: assert property (PIX_VALID && !PIX_READY |=> PIX_VALID && $stable(PIX_DATA)
      && $stable(PIX_FMT) && $stable(PIX_FIRST)) else $error("pixel word dropped");
   bpp_match_a: assert property (PIX_VALID && PIX_FIRST |-> PIX_BPP ==
      (PIX_FMT == 2'h0 ? 5'h10 : PIX_FMT == 2'h1 ? 5'h12 : 5'h18)) else $error("bad bpp");
   cover property ($rose(LP_OE));
   cover property ($rose(TERM_EN));
   cover property (PIX_VALID && !PIX_READY ##1 PIX_VALID && PIX_READY);
endmodule

bind dsls_rx dsls_rx_properties #(.DATA_W(DATA_W)) i_dsls_rx_properties (.CLK(CLK),
   .RESETN(RESETN), .LP_DP(LP_DP), .LP_DN(LP_DN), .LP_DP_O(LP_DP_O), .LP_DN_O(LP_DN_O),
   .LP_OE(LP_OE), .TERM_EN(TERM_EN), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY),
   .PIX_DATA(PIX_DATA), .PIX_FIRST(PIX_FIRST), .PIX_FMT(PIX_FMT), .PIX_BPP(PIX_BPP));

// ---- dsls_host.sv ----
// model: host side of lane 0 and of the link byte stream
module dsls_host (
   input wire logic CLK,
   input wire logic LP_OE,
   input wire logic LP_DP_O,
   input wire logic LP_DN_O,
   input wire logic LINK_READY,
   output logic LP_DP,
   output logic LP_DN,
   output logic LINK_CLK,
   output logic HS_VALID = 1'b0,
   output logic HS_SOP = 1'b0,
   output logic [7:0] HS_BYTE = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv = 1'b1;
   logic run = 1'b0;
   logic [1:0] hl = 2'h3;
   logic [1:0] fl = 2'h3;
   int stuck = 0;
   // a released lane has no pull, so it shows a level that flips each cycle
   always @(negedge CLK) fl <= ~fl;
   assign {LP_DP, LP_DN} = drv ? hl : LP_OE ? {LP_DP_O, LP_DN_O} : fl;
   // link clock stands still outside frames
   initial begin
      LINK_CLK = 1'b0;
      #3;
      forever #32 LINK_CLK = run ? ~LINK_CLK : 1'b0;
   end
   // one state period lasts n cycles, 7 cycles being 56 ns
   task automatic lane(input logic [1:0] l, input int n);
      @(negedge CLK);
      drv = 1'b1;
      hl = l;
      repeat (n - 1) @(negedge CLK);
   endtask
   task automatic let_go;
      @(negedge CLK);
      drv = 1'b0;
   endtask
   // a byte is held until an edge with room in the buffer
   task automatic put(input logic sop, input logic [7:0] b);
      int k;
      @(negedge LINK_CLK);
      HS_VALID = 1'b1;
      HS_SOP = sop;
      HS_BYTE = b;
      k = 0;
      do begin
         @(posedge LINK_CLK);
         k++;
      end while (!LINK_READY && k < 300);
      if (k >= 300) stuck++;
   endtask
   task automatic frame(input logic [7:0] code, input logic [7:0] base, input int n);
      run = 1'b1;
      put(1'b1, code);
      for (int i = 0; i < n; i++) put(1'b0, base + 8'(i));
      @(negedge LINK_CLK);
      HS_VALID = 1'b0;
      HS_BYTE = ~HS_BYTE;
      repeat (3) @(negedge LINK_CLK);
      run = 1'b0;
   endtask
endmodule

// ---- testbench.sv ----
// bench: self-checking run of the lane receiver against the host model
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK;
   logic RESETN;
   logic [2:0] LANE_COUNT;
   logic [9:0] LANE_MBPS;
   logic PIX_READY;
   logic LP_DP, LP_DN, LP_DP_O, LP_DN_O, LP_OE, TERM_EN, RATE_FAULT, LINK_CLK;
   logic HS_VALID, HS_SOP, LINK_READY, PIX_VALID, PIX_FIRST;
   logic [7:0] HS_BYTE;
   logic [7:0] PIX_DATA;
   logic [1:0] PIX_FMT;
   logic [4:0] PIX_BPP;
   int n_mismatch;
   int comparisons;
   dsls_rx #(.DATA_W(8)) i_dsls_rx (.CLK(CLK), .RESETN(RESETN), .LINK_CLK(LINK_CLK),
      .LP_DP(LP_DP), .LP_DN(LP_DN), .LP_DP_O(LP_DP_O), .LP_DN_O(LP_DN_O), .LP_OE(LP_OE),
      .TERM_EN(TERM_EN), .LANE_COUNT(LANE_COUNT), .LANE_MBPS(LANE_MBPS),
      .RATE_FAULT(RATE_FAULT), .HS_VALID(HS_VALID), .HS_SOP(HS_SOP), .HS_BYTE(HS_BYTE),
      .LINK_READY(LINK_READY), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY),
      .PIX_DATA(PIX_DATA), .PIX_FIRST(PIX_FIRST), .PIX_FMT(PIX_FMT), .PIX_BPP(PIX_BPP));
   dsls_host i_dsls_host (.CLK(CLK), .LP_OE(LP_OE), .LP_DP_O(LP_DP_O), .LP_DN_O(LP_DN_O),
      .LINK_READY(LINK_READY), .LP_DP(LP_DP), .LP_DN(LP_DN), .LINK_CLK(LINK_CLK),
      .HS_VALID(HS_VALID), .HS_SOP(HS_SOP), .HS_BYTE(HS_BYTE));
   //--------------------------------------------------------------
   // shared tasks
   //--------------------------------------------------------------
   task automatic tally_and_finish;
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // sel 0 watches PIX_VALID, sel 1 watches LP_OE; k returns the cycles waited
   task automatic await(input int sel, input logic v, output int k);
      for (k = 0; k < 400; k++) begin
         if ((sel == 0 ? PIX_VALID : LP_OE) === v) return;
         @(negedge CLK);
      end
      n_mismatch++;
      tally_and_finish();
   endtask
   //--------------------------------------------------------------
   // scenarios
   //--------------------------------------------------------------
   task automatic t_pixels(input logic [7:0] code, input logic [1:0] fmt, input logic [4:0] bpp,
         input logic [2:0] lanes, input logic [9:0] lim, input logic over);
      int k;
      @(negedge CLK);
      LANE_COUNT = lanes;
      LANE_MBPS = lim + {9'h000, over};
      PIX_READY = 1'b0;
      fork
         i_dsls_host.frame(code, {fmt, 6'h10}, 3);
         begin
            repeat (64) @(negedge CLK);
            check(16'(LINK_READY), 16'h0000);
            PIX_READY = 1'b1;
            for (int i = 0; i < 3; i++) begin
               await(0, 1'b1, k);
               check({PIX_FIRST, PIX_FMT, PIX_BPP, PIX_DATA},
                  {i == 0, fmt, bpp, {fmt, 6'h10} + 8'(i)});
               @(negedge CLK);
            end
         end
      join
      check(16'(RATE_FAULT), 16'(over));
   endtask
   task automatic t_reject;
      int seen;
      seen = 0;
      fork
         i_dsls_host.frame(8'h4E, 8'hA5, 3);
         repeat (80) begin
            @(negedge CLK);
            seen += int'(PIX_VALID === 1'b1);
         end
      join
      check(16'(seen), 16'h0000);
   endtask
   task automatic t_hs;
      i_dsls_host.lane(2'h3, 13);
      i_dsls_host.lane(2'h1, 7);
      check(16'(TERM_EN), 16'h0001);
      i_dsls_host.lane(2'h0, 7);
      check(16'(TERM_EN), 16'h0001);
      i_dsls_host.lane(2'h3, 13);
      check(16'(TERM_EN), 16'h0000);
      i_dsls_host.lane(2'h1, 7);
      i_dsls_host.lane(2'h2, 7);
      check(16'(TERM_EN), 16'h0000);
      i_dsls_host.lane(2'h3, 13);
   endtask
   task automatic t_ta;
      int k;
      int z;
      i_dsls_host.lane(2'h2, 7);
      i_dsls_host.lane(2'h0, 7);
      i_dsls_host.lane(2'h2, 7);
      i_dsls_host.lane(2'h0, 28);
      i_dsls_host.let_go();
      await(1, 1'b1, k);
      z = 0;
      while (LP_OE === 1'b1 && {LP_DP_O, LP_DN_O} === 2'h0 && z < 100) begin
         z++;
         @(negedge CLK);
      end
      check(16'(z), 16'h0028);
      check(16'({LP_OE, LP_DP_O, LP_DN_O}), 16'h0006);
      await(1, 1'b0, k);
      check(16'(k), 16'h0030);
      i_dsls_host.lane(2'h3, 13);
   endtask
   //--------------------------------------------------------------
   // main sequence
   //--------------------------------------------------------------
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   initial begin
      #500000;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      RESETN = 1'b0;
      LANE_COUNT = 3'h2;
      LANE_MBPS = 10'h000;
      PIX_READY = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      i_dsls_host.run = 1'b1;
      repeat (2) @(negedge CLK);
      // the link side clears at once on RESETN low, like the system side
      repeat (3) @(posedge LINK_CLK);
      @(negedge CLK);
      check({LP_OE, TERM_EN, PIX_VALID, LINK_READY}, 16'h0001);
      RESETN = 1'b1;
      repeat (5) @(posedge LINK_CLK);
      i_dsls_host.run = 1'b0;
      @(negedge CLK);
      t_hs();
      t_ta();
      t_pixels(8'h0E, 2'h0, 5'h10, 3'h4, 10'h16E, 1'b0);
      t_pixels(8'h1E, 2'h1, 5'h12, 3'h3, 10'h20D, 1'b1);
      t_reject();
      t_pixels(8'h2E, 2'h2, 5'h18, 3'h2, 10'h352, 1'b0);
      t_pixels(8'h3E, 2'h3, 5'h18, 3'h4, 10'h226, 1'b1);
      check(16'(i_dsls_host.stuck), 16'h0000);
      tally_and_finish();
   end
endmodule
